// ==== pkg/cvf_pkg.sv ====
// Functional notes
// - Command 32h returns channel 1 voltage, LSB first
// - Commands 36h/3Ah/3Eh return channels 2-4 voltage
// - 14-bit code, top two bits zero, reset zero
// - Code times 3.662 mV, 60 V full scale
// - Command 40h: foldback bits 7-4, policing 3-0
// - Foldback enable doubles current-limit and short levels
// - Fault timer starts when current exceeds limit
// - Inrush profile unaffected by foldback enables
// - Fault time nominal 60 ms, else timing config
// - Class 4 or above sets foldback at turn-on
// - Policing clear: class adjusts cut and foldback
// - Policing set: cut and foldback left unchanged
// - Turn-off restores cut threshold and foldback defaults
// - Turn-off clears the manual policing flag
// - Four-pair port: either flag holds both channels
package cvf_pkg;

  localparam int NUM_CHAN = 4;
  localparam int CODE_W   = 14;
  localparam int CLASS_W  = 3;
  localparam int POWER_CUT_THRESHOLD_W   = 8;
  localparam int TMR_W    = 24;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_VOLT_CH1 = 8'h32;
  localparam logic [7:0] CMD_VOLT_CH2 = 8'h36;
  localparam logic [7:0] CMD_VOLT_CH3 = 8'h3a;
  localparam logic [7:0] CMD_VOLT_CH4 = 8'h3e;
  localparam logic [7:0] CMD_FOLDBACK = 8'h40;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int FB_LSB   = 4;
  localparam int MPOL_LSB = 0;
  localparam logic [3:0]        FB_RESET    = 4'h0;
  localparam logic [3:0]        MPOL_RESET  = 4'h0;
  localparam logic [CODE_W-1:0] VOLT_RESET  = 14'h0000;
  localparam logic [7:0]        RD_UNMAPPED = 8'h00;
  localparam logic [POWER_CUT_THRESHOLD_W-1:0] POWER_CUT_THRESHOLD_DEFAULT = 8'hff;
  localparam logic [CLASS_W-1:0] FB_CLASS_MIN = 3'h4;

  // ****************************************
  // Scaling and timing
  // ****************************************
  localparam int VOLT_LSB_UV   = 3662;
  localparam int VOLT_FS_MV    = 60000;
  localparam int CLK_KHZ       = 125000;
  localparam int LIMIT_FAULT_TIME_NOM_MS   = 60;
  localparam int LIMIT_FAULT_TIME_PROG0_MS = 15;
  localparam int LIMIT_FAULT_TIME_PROG1_MS = 30;
  localparam int LIMIT_FAULT_TIME_PROG2_MS = 60;
  localparam int LIMIT_FAULT_TIME_PROG3_MS = 120;

  typedef logic [CODE_W-1:0] cvf_code_t;

endpackage

// ==== pkg/cvf_volt_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Voltage store access
// ****************************************
interface cvf_volt_if;
  import cvf_pkg::*;
  logic            wr_en;
  logic [1:0]      wr_chan;
  cvf_code_t       wr_code;
  logic            rd_en;
  logic [1:0]      rd_chan;
  cvf_code_t       rd_code;

  modport store (
    input  wr_en, wr_chan, wr_code, rd_en, rd_chan,
    output rd_code
  );
  modport owner (
    output wr_en, wr_chan, wr_code, rd_en, rd_chan,
    input  rd_code
  );
endinterface
`default_nettype wire

// ==== src/cvf_volt_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module cvf_volt_store
  import cvf_pkg::*;
(
  // Clock and reset
  input wire logic      mclk,
  input wire logic      reset_n,
  // Access port
  cvf_volt_if.store     vp
);

  cvf_code_t mem_q [NUM_CHAN];
  cvf_code_t rd_code_q;

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_word
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          mem_q[g] <= VOLT_RESET;
        end else if (vp.wr_en && (vp.wr_chan == 2'(g))) begin
          mem_q[g] <= vp.wr_code;
        end
      end
    end
  endgenerate

  // Read word holds until the next low-byte voltage read, acting as snapshot
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_code_q <= VOLT_RESET;
    end else if (vp.rd_en) begin
      rd_code_q <= mem_q[vp.rd_chan];
    end
  end

  assign vp.rd_code = rd_code_q;

endmodule
`default_nettype wire

// ==== src/cvf_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module cvf_regs
  import cvf_pkg::*;
#(
  parameter int unsigned LIMIT_FAULT_TIME_NOM_CYC   = LIMIT_FAULT_TIME_NOM_MS * CLK_KHZ,
  parameter int unsigned LIMIT_FAULT_TIME_PROG0_CYC = LIMIT_FAULT_TIME_PROG0_MS * CLK_KHZ,
  parameter int unsigned LIMIT_FAULT_TIME_PROG1_CYC = LIMIT_FAULT_TIME_PROG1_MS * CLK_KHZ,
  parameter int unsigned LIMIT_FAULT_TIME_PROG2_CYC = LIMIT_FAULT_TIME_PROG2_MS * CLK_KHZ,
  parameter int unsigned LIMIT_FAULT_TIME_PROG3_CYC = LIMIT_FAULT_TIME_PROG3_MS * CLK_KHZ
) (
  // Clock and reset
  input  wire logic                             mclk,
  input  wire logic                             reset_n,
  // Command port from serial engine
  input  wire logic                             mgmt_cmd_strobe,
  input  wire logic [7:0]                       mgmt_cmd_code,
  input  wire logic                             mgmt_wr_strobe,
  input  wire logic [7:0]                       mgmt_wr_byte,
  input  wire logic                             mgmt_rd_strobe,
  output logic      [7:0]                       mgmt_rd_byte,
  output logic                                  mgmt_rd_valid,
  // Converter results
  input  wire logic [NUM_CHAN-1:0]              conv_valid,
  input  wire logic [NUM_CHAN-1:0][CODE_W-1:0]  channel_voltage_code,
  // Port sequencing
  input  wire logic [NUM_CHAN-1:0]              port_turn_on,
  input  wire logic [NUM_CHAN-1:0]              port_turn_off,
  input  wire logic [NUM_CHAN-1:0][CLASS_W-1:0] assigned_class,
  input  wire logic [1:0]                       four_pair_cfg,
  input  wire logic [NUM_CHAN-1:0]              inrush_active,
  input  wire logic [NUM_CHAN-1:0][1:0]         limit_time_sel,
  input  wire logic [NUM_CHAN-1:0]              over_limit_raw,
  // Channel controls
  output logic      [NUM_CHAN-1:0]              double_foldback_enable,
  output logic      [NUM_CHAN-1:0]              manual_policing_hold,
  output logic      [NUM_CHAN-1:0]              current_limit_level_2x,
  output logic      [NUM_CHAN-1:0]              short_circuit_level_2x,
  output logic      [NUM_CHAN-1:0][POWER_CUT_THRESHOLD_W-1:0]  power_cut_threshold,
  output logic      [NUM_CHAN-1:0]              fault_timer_running,
  output logic      [NUM_CHAN-1:0]              limit_fault
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic volt_cmd_hit(input logic [7:0] code);
    volt_cmd_hit = (code == CMD_VOLT_CH1) || (code == CMD_VOLT_CH2) ||
                   (code == CMD_VOLT_CH3) || (code == CMD_VOLT_CH4);
  endfunction

  function automatic logic [1:0] volt_cmd_chan(input logic [7:0] code);
    case (code)
      CMD_VOLT_CH2: volt_cmd_chan = 2'h1;
      CMD_VOLT_CH3: volt_cmd_chan = 2'h2;
      CMD_VOLT_CH4: volt_cmd_chan = 2'h3;
      default:      volt_cmd_chan = 2'h0;
    endcase
  endfunction

  // Power cut per class; values above class 4 saturate
  function automatic logic [POWER_CUT_THRESHOLD_W-1:0] power_cut_threshold_for_class(input logic [CLASS_W-1:0] cls);
    case (cls)
      3'h0:    power_cut_threshold_for_class = 8'h0f;
      3'h1:    power_cut_threshold_for_class = 8'h04;
      3'h2:    power_cut_threshold_for_class = 8'h07;
      3'h3:    power_cut_threshold_for_class = 8'h0f;
      3'h4:    power_cut_threshold_for_class = 8'h1e;
      default: power_cut_threshold_for_class = 8'h3c;
    endcase
  endfunction

  // ****************************************
  // Command pointer and byte index
  // ****************************************
  logic [7:0] cmd_q;
  logic       byte_hi_q;
  logic       byte_over_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_q <= 8'h00;
    end else if (mgmt_cmd_strobe) begin
      cmd_q <= mgmt_cmd_code;
    end
  end

  // Bytes past the second of a transfer read as unmapped
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      byte_hi_q   <= 1'b0;
      byte_over_q <= 1'b0;
    end else if (mgmt_cmd_strobe) begin
      byte_hi_q   <= 1'b0;
      byte_over_q <= 1'b0;
    end else if (mgmt_rd_strobe || mgmt_wr_strobe) begin
      byte_hi_q   <= 1'b1;
      byte_over_q <= byte_hi_q;
    end
  end

  // ****************************************
  // Voltage store
  // ****************************************
  cvf_volt_if vif ();
  logic [1:0] conv_chan;
  logic       rd_volt_lo;

  always_comb begin
    conv_chan = 2'h0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (conv_valid[i]) begin
        conv_chan = 2'(i);
      end
    end
  end

  // One result per cycle; converters post on staggered cycles
  assign vif.wr_en   = |conv_valid;
  assign vif.wr_chan = conv_chan;
  assign vif.wr_code = channel_voltage_code[conv_chan];

  assign rd_volt_lo  = mgmt_rd_strobe && !byte_hi_q && volt_cmd_hit(cmd_q);
  assign vif.rd_en   = rd_volt_lo;
  assign vif.rd_chan = volt_cmd_chan(cmd_q);

  cvf_volt_store u_store (
    .mclk    (mclk),
    .reset_n (reset_n),
    .vp      (vif.store)
  );

  // ****************************************
  // Read pipeline
  // ****************************************
  logic       rd_pend_q;
  logic       rd_hi_q;
  logic       rd_over_q;
  logic [7:0] rd_cmd_q;
  logic [7:0] rd_byte_d;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_pend_q <= 1'b0;
      rd_hi_q   <= 1'b0;
      rd_over_q <= 1'b0;
      rd_cmd_q  <= 8'h00;
    end else begin
      rd_pend_q <= mgmt_rd_strobe;
      rd_hi_q   <= byte_hi_q;
      rd_over_q <= byte_over_q;
      rd_cmd_q  <= cmd_q;
    end
  end

  always_comb begin
    rd_byte_d = RD_UNMAPPED;
    if (volt_cmd_hit(rd_cmd_q) && !rd_over_q) begin
      if (rd_hi_q) begin
        rd_byte_d = {2'b00, vif.rd_code[CODE_W-1:8]};
      end else begin
        rd_byte_d = vif.rd_code[7:0];
      end
    end else if ((rd_cmd_q == CMD_FOLDBACK) && !rd_hi_q) begin
      rd_byte_d = {double_foldback_enable, manual_policing_hold};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mgmt_rd_valid <= 1'b0;
      mgmt_rd_byte  <= RD_UNMAPPED;
    end else begin
      mgmt_rd_valid <= rd_pend_q;
      if (rd_pend_q) begin
        mgmt_rd_byte <= rd_byte_d;
      end
    end
  end

  // ****************************************
  // Foldback and policing register
  // ****************************************
  logic       host_wr_fb;
  logic [3:0] hold;
  logic [3:0] partner_mpol;
  logic [3:0] pair_4p;

  assign host_wr_fb   = mgmt_wr_strobe && !byte_hi_q && (cmd_q == CMD_FOLDBACK);
  assign partner_mpol = {manual_policing_hold[2], manual_policing_hold[3],
                         manual_policing_hold[0], manual_policing_hold[1]};
  assign pair_4p      = {four_pair_cfg[1], four_pair_cfg[1],
                         four_pair_cfg[0], four_pair_cfg[0]};
  assign hold         = manual_policing_hold | (pair_4p & partner_mpol);

  genvar c;
  generate
    for (c = 0; c < NUM_CHAN; c++) begin : g_chan
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          double_foldback_enable[c] <= FB_RESET[c];
        end else if (port_turn_off[c]) begin
          double_foldback_enable[c] <= FB_RESET[c];
        end else if (port_turn_on[c] && !hold[c]) begin
          double_foldback_enable[c] <= (assigned_class[c] >= FB_CLASS_MIN);
        end else if (host_wr_fb) begin
          double_foldback_enable[c] <= mgmt_wr_byte[FB_LSB + c];
        end
      end

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          manual_policing_hold[c] <= MPOL_RESET[c];
        end else if (port_turn_off[c]) begin
          manual_policing_hold[c] <= MPOL_RESET[c];
        end else if (host_wr_fb) begin
          manual_policing_hold[c] <= mgmt_wr_byte[MPOL_LSB + c];
        end
      end

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          power_cut_threshold[c] <= POWER_CUT_THRESHOLD_DEFAULT;
        end else if (port_turn_off[c]) begin
          power_cut_threshold[c] <= POWER_CUT_THRESHOLD_DEFAULT;
        end else if (port_turn_on[c] && !hold[c]) begin
          power_cut_threshold[c] <= power_cut_threshold_for_class(assigned_class[c]);
        end
      end

      // Inrush keeps its own profile, so foldback waits it out
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          current_limit_level_2x[c] <= 1'b0;
          short_circuit_level_2x[c] <= 1'b0;
        end else begin
          current_limit_level_2x[c] <= double_foldback_enable[c] && !inrush_active[c];
          short_circuit_level_2x[c] <= double_foldback_enable[c] && !inrush_active[c];
        end
      end
    end
  endgenerate

  // ****************************************
  // Limit fault timers
  // ****************************************
  logic [NUM_CHAN-1:0] over_meta_q;
  logic [NUM_CHAN-1:0] over_sync_q;

  // Comparator is analog and asynchronous to mclk
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      over_meta_q <= '0;
      over_sync_q <= '0;
    end else begin
      over_meta_q <= over_limit_raw;
      over_sync_q <= over_meta_q;
    end
  end

  function automatic logic [TMR_W-1:0] limit_cycles(input logic fb, input logic [1:0] sel);
    logic [TMR_W-1:0] prog;
    case (sel)
      2'h0:    prog = TMR_W'(LIMIT_FAULT_TIME_PROG0_CYC);
      2'h1:    prog = TMR_W'(LIMIT_FAULT_TIME_PROG1_CYC);
      2'h2:    prog = TMR_W'(LIMIT_FAULT_TIME_PROG2_CYC);
      default: prog = TMR_W'(LIMIT_FAULT_TIME_PROG3_CYC);
    endcase
    limit_cycles = fb ? prog : TMR_W'(LIMIT_FAULT_TIME_NOM_CYC);
  endfunction

  generate
    for (c = 0; c < NUM_CHAN; c++) begin : g_tmr
      logic [TMR_W-1:0] tmr_q;
      logic [TMR_W-1:0] tmr_lim;

      assign tmr_lim = limit_cycles(double_foldback_enable[c], limit_time_sel[c]);

      // Timer restarts whenever current drops back under the limit
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          tmr_q <= '0;
        end else if (!over_sync_q[c] || port_turn_off[c]) begin
          tmr_q <= '0;
        end else if (tmr_q < tmr_lim) begin
          tmr_q <= tmr_q + TMR_W'(1);
        end
      end

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          fault_timer_running[c] <= 1'b0;
        end else begin
          fault_timer_running[c] <= over_sync_q[c] && !port_turn_off[c];
        end
      end

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          limit_fault[c] <= 1'b0;
        end else if (over_sync_q[c] && (tmr_q >= tmr_lim)) begin
          limit_fault[c] <= 1'b1;
        end else if (port_turn_off[c]) begin
          limit_fault[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // Measurement scaling
  // ****************************************
  // Code N means N * 3662 uV; full scale is 60 V, code 16384, one past
  // the top 14-bit code 16383; the stored code is passed unaltered.
  localparam int VOLT_FS_CODE = (VOLT_FS_MV * 1000) / VOLT_LSB_UV;

endmodule
`default_nettype wire

// ==== src/cvf_unused_placeholder_none.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== tb/cvf_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module cvf_regs_asserts
  import cvf_pkg::*;
(
  // Clock and reset
  input wire logic            mclk,
  input wire logic            reset_n,
  // Command port
  input wire logic            mgmt_cmd_strobe,
  input wire logic [7:0]      mgmt_cmd_code,
  input wire logic            mgmt_wr_strobe,
  input wire logic [7:0]      mgmt_wr_byte,
  input wire logic            mgmt_rd_strobe,
  input wire logic            mgmt_rd_valid,
  // Port sequencing
  input wire logic [3:0]      port_turn_on,
  input wire logic [3:0]      port_turn_off,
  input wire logic [3:0][2:0] assigned_class,
  input wire logic [1:0]      four_pair_cfg,
  input wire logic [3:0]      inrush_active,
  // Channel controls
  input wire logic [3:0]      double_foldback_enable,
  input wire logic [3:0]      manual_policing_hold,
  input wire logic [3:0]      current_limit_level_2x,
  input wire logic [3:0]      short_circuit_level_2x,
  input wire logic [3:0][7:0] power_cut_threshold
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Partner flag counts on a four-pair port
  logic hold0;
  assign hold0 = manual_policing_hold[0] | (four_pair_cfg[0] & manual_policing_hold[1]);

  sequence s_wr40;
    mgmt_cmd_strobe && mgmt_cmd_code == CMD_FOLDBACK
      ##1 mgmt_wr_strobe && port_turn_on == 4'h0 && port_turn_off == 4'h0;
  endsequence
  sequence s_on0;
    port_turn_on[0] && !port_turn_off[0];
  endsequence

  property p_rd_lat;
    mgmt_rd_strobe |-> ##2 mgmt_rd_valid;
  endproperty
  property p_rd_src;
    mgmt_rd_valid |-> $past(mgmt_rd_strobe, 2);
  endproperty
  property p_wr40;
    s_wr40 |=> {double_foldback_enable, manual_policing_hold} == $past(mgmt_wr_byte);
  endproperty
  property p_on_auto;
    s_on0 ##0 !hold0 |=> double_foldback_enable[0] == ($past(assigned_class[0]) >= 3'h4);
  endproperty
  property p_on_hold;
    s_on0 ##0 (hold0 && !mgmt_wr_strobe)
      |=> $stable(double_foldback_enable[0]) && $stable(power_cut_threshold[0]);
  endproperty
  property p_off;
    port_turn_off != 4'h0
      |=> ((double_foldback_enable | manual_policing_hold) & $past(port_turn_off)) == 4'h0;
  endproperty
  property p_lvl;
    current_limit_level_2x == $past(double_foldback_enable & ~inrush_active);
  endproperty
  property p_sc;
    short_circuit_level_2x == current_limit_level_2x;
  endproperty

  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_rd_src: assert property (p_rd_src) else $error("read answer unasked");
  a_wr40: assert property (p_wr40) else $error("foldback write lost");
  a_on_auto: assert property (p_on_auto) else $error("class foldback wrong");
  a_on_hold: assert property (p_on_hold) else $error("held channel changed");
  a_off: assert property (p_off) else $error("turn-off left bits set");
  a_lvl: assert property (p_lvl) else $error("limit level wrong");
  a_sc: assert property (p_sc) else $error("short level differs");
endmodule

bind cvf_regs cvf_regs_asserts u_chk (.mclk, .reset_n, .mgmt_cmd_strobe, .mgmt_cmd_code,
  .mgmt_wr_strobe, .mgmt_wr_byte, .mgmt_rd_strobe, .mgmt_rd_valid, .port_turn_on,
  .port_turn_off, .assigned_class, .four_pair_cfg, .inrush_active, .double_foldback_enable,
  .manual_policing_hold, .current_limit_level_2x, .short_circuit_level_2x,
  .power_cut_threshold);
`default_nettype wire

// ==== tb/cvf_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cvf_host_model (
  // Clock
  input wire logic  mclk,
  // Command port
  output logic       mgmt_cmd_strobe,
  output logic [7:0] mgmt_cmd_code,
  output logic       mgmt_wr_strobe,
  output logic [7:0] mgmt_wr_byte,
  output logic       mgmt_rd_strobe
);
  initial begin
    mgmt_cmd_strobe = 1'b0;
    mgmt_wr_strobe = 1'b0;
    mgmt_rd_strobe = 1'b0;
    mgmt_cmd_code = 8'h00;
    mgmt_wr_byte = 8'h00;
  end
  // One cycle per call: 0 cmd, 1 wr, 2 rd, 3 idle; idle data toggles
  task automatic xfer(input int k, input logic [7:0] d);
    @(negedge mclk);
    mgmt_cmd_strobe = (k == 0);
    mgmt_wr_strobe = (k == 1);
    mgmt_rd_strobe = (k == 2);
    mgmt_cmd_code = (k == 3) ? ~mgmt_cmd_code : d;
    mgmt_wr_byte = (k == 3) ? ~mgmt_wr_byte : d;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cvf_pkg::*;
  localparam int NOM = 20;
  localparam int P0 = 5;
  logic mclk = 1'b0;
  logic reset_n, mgmt_cmd_strobe, mgmt_wr_strobe, mgmt_rd_strobe, mgmt_rd_valid;
  logic [7:0] mgmt_cmd_code, mgmt_wr_byte, mgmt_rd_byte, w;
  logic [3:0] conv_valid, port_turn_on, port_turn_off, inrush_active, over_limit_raw;
  logic [3:0] double_foldback_enable, manual_policing_hold, current_limit_level_2x;
  logic [3:0] short_circuit_level_2x, fault_timer_running, limit_fault;
  logic [3:0][CODE_W-1:0] channel_voltage_code;
  logic [3:0][2:0] assigned_class;
  logic [3:0][1:0] limit_time_sel;
  logic [3:0][7:0] power_cut_threshold;
  logic [1:0] four_pair_cfg;
  logic [13:0] v;
  logic [7:0] exp_q[$];
  logic [7:0] vcmd[4] = '{CMD_VOLT_CH1, CMD_VOLT_CH2, CMD_VOLT_CH3, CMD_VOLT_CH4};
  int num_errors = 0;
  int compares = 0;

  always #4 mclk = ~mclk;

  cvf_host_model host (.mclk, .mgmt_cmd_strobe, .mgmt_cmd_code, .mgmt_wr_strobe,
    .mgmt_wr_byte, .mgmt_rd_strobe);
  // Short fault times keep the run brief
  cvf_regs #(.LIMIT_FAULT_TIME_NOM_CYC(NOM), .LIMIT_FAULT_TIME_PROG0_CYC(P0), .LIMIT_FAULT_TIME_PROG1_CYC(10),
    .LIMIT_FAULT_TIME_PROG2_CYC(20), .LIMIT_FAULT_TIME_PROG3_CYC(40)) dut (.mclk, .reset_n, .mgmt_cmd_strobe,
    .mgmt_cmd_code, .mgmt_wr_strobe, .mgmt_wr_byte, .mgmt_rd_strobe, .mgmt_rd_byte,
    .mgmt_rd_valid, .conv_valid, .channel_voltage_code, .port_turn_on, .port_turn_off,
    .assigned_class, .four_pair_cfg, .inrush_active, .limit_time_sel, .over_limit_raw,
    .double_foldback_enable, .manual_policing_hold, .current_limit_level_2x,
    .short_circuit_level_2x, .power_cut_threshold, .fault_timer_running, .limit_fault);

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input logic [3:0] on = 4'h0, off = 4'h0, cv = 4'h0);
    host.xfer(3, 8'h00);
    port_turn_on = on;
    port_turn_off = off;
    conv_valid = cv;
  endtask
  task automatic rd(input logic [7:0] e);
    host.xfer(2, 8'h00);
    exp_q.push_back(e);
  endtask
  task automatic load(input int ch, input logic [13:0] c);
    channel_voltage_code[ch] = c;
    step(4'h0, 4'h0, 4'h1 << ch);
    step();
  endtask
  task automatic wait_fault(input int n);
    for (int i = 0; i < n && limit_fault[0] !== 1'b1; i++) step();
    chk(limit_fault[0], 1'b1);
    if (limit_fault[0] !== 1'b1) complete_run();
  endtask
  function automatic logic [7:0] power_cut_threshold_of(input int c);
    case (c)
      0, 3: return 8'h0f;
      1: return 8'h04;
      2: return 8'h07;
      4: return 8'h1e;
      default: return 8'h3c;
    endcase
  endfunction

  // ****************
  // Read answer watcher
  // ****************
  always @(negedge mclk) begin
    if (mgmt_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(16'h0001, 16'h0000);
      else chk(mgmt_rd_byte, exp_q.pop_front());
    end
  end

  initial begin
    void'($urandom(17821));
    {reset_n, conv_valid, port_turn_on, port_turn_off, inrush_active, over_limit_raw} = '0;
    {channel_voltage_code, assigned_class, limit_time_sel, four_pair_cfg} = '0;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      chk(power_cut_threshold[i], 8'hff);
      host.xfer(0, vcmd[i]);
      rd(8'h00);
      rd(8'h00);
    end
    host.xfer(0, CMD_FOLDBACK);
    rd(8'h00);
    host.xfer(0, 8'h41);
    rd(8'h00);
    // Snapshot: new code lands between the two byte reads
    for (int i = 0; i < 4; i++) begin
      v = 14'($urandom);
      load(i, v);
      host.xfer(0, vcmd[i]);
      rd(v[7:0]);
      load(i, ~v);
      rd({2'b00, v[13:8]});
      rd(8'h00);
      host.xfer(0, vcmd[i]);
      rd(~v[7:0]);
      rd({2'b00, ~v[13:8]});
      host.xfer(1, 8'hff);
    end
    w = 8'($urandom);
    host.xfer(0, CMD_FOLDBACK);
    host.xfer(1, w);
    host.xfer(1, ~w);
    host.xfer(0, CMD_FOLDBACK);
    rd(w);
    step();
    chk({double_foldback_enable, manual_policing_hold}, w);
    step(4'h0, 4'hf);
    for (int c = 0; c < 8; c++) begin
      assigned_class[0] = 3'(c);
      step(4'h1);
      step();
      chk(double_foldback_enable[0], c >= 4);
      chk(power_cut_threshold[0], power_cut_threshold_of(c));
      step(4'h0, 4'h1);
      step();
      chk({double_foldback_enable[0], power_cut_threshold[0]}, 9'h0ff);
    end
    host.xfer(0, CMD_FOLDBACK);
    host.xfer(1, 8'h01);
    step(4'h1);
    step();
    chk({double_foldback_enable[0], power_cut_threshold[0]}, 9'h0ff);
    step(4'h0, 4'h1);
    step();
    chk(manual_policing_hold[0], 1'b0);
    four_pair_cfg = 2'b01;
    host.xfer(0, CMD_FOLDBACK);
    host.xfer(1, 8'h02);
    step(4'h1);
    step(4'h0, 4'h2);
    chk(double_foldback_enable[0], 1'b0);
    four_pair_cfg = 2'b00;
    host.xfer(0, CMD_FOLDBACK);
    host.xfer(1, 8'h00);
    port_turn_on = 4'h1;
    step();
    chk(double_foldback_enable[0], 1'b1);
    host.xfer(0, CMD_FOLDBACK);
    host.xfer(1, 8'hff);
    port_turn_off = 4'h1;
    step();
    chk({double_foldback_enable, manual_policing_hold}, 8'hee);
    step();
    chk(current_limit_level_2x, 4'he);
    inrush_active = 4'h2;
    step(4'h0, 4'hf);
    chk(short_circuit_level_2x, 4'hc);
    step();
    step();
    chk(short_circuit_level_2x, 4'h0);
    inrush_active = 4'h0;
    over_limit_raw = 4'h1;
    repeat (NOM - 4) step();
    chk({fault_timer_running[0], limit_fault[0]}, 2'b10);
    wait_fault(12);
    over_limit_raw = 4'h0;
    // Let the synchroniser drain so turn-off is not beaten by a fresh set
    step();
    step(4'h0, 4'h1);
    step();
    host.xfer(0, CMD_FOLDBACK);
    host.xfer(1, 8'h10);
    chk(limit_fault[0], 1'b0);
    limit_time_sel[0] = 2'h1;
    over_limit_raw = 4'h1;
    repeat (P0 + 4) step();
    chk(limit_fault[0], 1'b0);
    wait_fault(8);
    repeat (4) step();
    chk(16'(exp_q.size()), 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
